// ==== rtl/rf_pin_reset_sequencing_ctrl.sv ====
// pin/interface config, submodule soft resets and auto power-up sequencer
// assumes a config port decoder giving write and read strobes, analog
// status on mclk, and adc/filter clock enables from the dividers
//
// How it works
// R1 - bypass bit powers oscillator down, takes external
// R2 - split bit moves rx data off data pin
// R3 - data pin falling edge triggers when selected and split bit set
// R4 - lock gating holds data clock high unlocked, in sync mode and power-down mode both only
// R5 - carrier gating holds data clock high without carrier, in sync mode only
// R6 - host keeps carrier gating off in tx
// R7 - tx amp pin static or follows internal pa
// R8 - rx amp pin static or follows internal lna
// R9 - tx polarity bit sets pin active level
// R10 - rx polarity bit sets pin active level
// R11 - test enables route low bits to test
// R12 - each low reset bit resets one unit
// R13 - reset bits self clear when reset starts
// R14 - host polls reset done until all ones
// R15 - host prefers whole-chip reset normally
// R16 - power select falling edge triggers when selected
// R17 - rx wait counts adc periods after lock
// R18 - carrier wait counts filter periods after rx
// R19 - sequencing only with auto mode in rx
// R20 - rising power-down request returns to power-down
// R21 - calibration interval never, always, 16th, 256th
// R22 - trigger pins synchronised, one edge one sequence
// R23 - no carrier at timeout returns to power-down
`timescale 1ns/1ps
`default_nettype none
module rf_pin_reset_sequencing_ctrl
  import rf_seq_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic [rf_seq_pkg::ADDR_W-1:0] cfgAddr,
  input  wire logic                          cfgWrEn,
  input  wire logic [7:0]                    cfgWrData,
  input  wire logic                          cfgRdEn,
  input  wire logic                          rxTxSelect,
  input  wire logic [1:0]                    powerdownMode,
  input  wire logic [1:0]                    seqPllCalInterval,
  input  wire logic                          seqEnterPowerdown,
  input  wire logic                          analogTestEnableF,
  input  wire logic                          analogTestEnableA,
  input  wire logic                          dataIoPinIn,
  input  wire logic                          powerSelPin,
  input  wire logic                          syncMode,
  input  wire logic                          pllLock,
  input  wire logic                          carrierSense,
  input  wire logic                          paOn,
  input  wire logic                          lnaOn,
  input  wire logic                          rxData,
  input  wire logic                          dataClkRaw,
  input  wire logic                          adcClkEn,
  input  wire logic                          filterClkEn,
  input  wire logic [7:0]                    unitClkRunning,
  output logic      [7:0]                    cfgRdData,
  output logic                               oscPowerdown,
  output logic                               extClockSel,
  output logic                               dataIoPinOut,
  output logic                               dataIoPinOe_n,
  output logic                               lockPinOut,
  output logic                               dataClockPinOut,
  output logic                               txAmpEnablePin,
  output logic                               rxAmpEnablePin,
  output logic                               analogTestPowerdown,
  output logic      [2:0]                    testMode,
  output logic      [7:0]                    unitRst_n,
  output logic                               rxChainOn,
  output logic                               synthOn,
  output logic                               pllCalStart
);
  import rf_seq_pkg::*;

  logic [7:0] ifCfg_q, ifCfg_d, srst_q, srst_d, seqCfg_q, seqCfg_d;
  logic [7:0] done_q, done_d, rd_q, rd_d;
  logic       wrIf, wrSrst, wrSeq;

  assign wrIf = cfgWrEn && cfgAddr == ADDR_IF;
  assign wrSrst = cfgWrEn && cfgAddr == ADDR_SRST;
  assign wrSeq = cfgWrEn && cfgAddr == ADDR_SEQ;

  // register file; a written zero starts a unit reset and reads back as one
  always_comb begin
    ifCfg_d = wrIf ? cfgWrData : ifCfg_q;
    seqCfg_d = wrSeq ? cfgWrData : seqCfg_q;
    srst_d = wrSrst ? cfgWrData : ALL_ONES; // see R13
    for (int i = 0; i < 8; i++) begin
      if (!srst_q[i]) begin
        done_d[i] = 1'b0;
      end else begin
        done_d[i] = done_q[i] | unitClkRunning[i]; // see R14
      end
    end
    rd_d = READ_ZERO;
    if (cfgRdEn) begin
      unique case (cfgAddr)
        ADDR_IF:        rd_d = ifCfg_q;
        ADDR_SRST:      rd_d = srst_q;
        ADDR_SEQ:       rd_d = seqCfg_q;
        ADDR_SRST_DONE: rd_d = done_q;
        default:        rd_d = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ifCfg_q <= IF_RESET;
      srst_q <= SRST_RESET;
      seqCfg_q <= SEQ_RESET;
      done_q <= READ_ZERO;
      rd_q <= READ_ZERO;
    end else begin
      ifCfg_q <= ifCfg_d;
      srst_q <= srst_d;
      seqCfg_q <= seqCfg_d;
      done_q <= done_d;
      rd_q <= rd_d;
    end
  end

  // trigger pins: two stages, then edge detect on the clean copy
  logic [1:0] meta_q, sync_q, prev_q;
  logic       dioFall, pselFall, seqEn, trig;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= {powerSelPin, dataIoPinIn}; // see R22
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign dioFall = prev_q[0] && !sync_q[0]; // see R22
  assign pselFall = prev_q[1] && !sync_q[1];
  assign seqEn = powerdownMode == POWERDOWN_MODE_AUTO && !rxTxSelect; // see R19
  assign trig = (seqCfg_q[TRIGGER_PIN_SELECT] && pselFall) // see R16
             || (!seqCfg_q[TRIGGER_PIN_SELECT] && ifCfg_q[IF_SPLIT] && dioFall); // see R3

  // sequencer; the soft reset bit for it acts like the chip reset
  seq_state_e st_q, st_d;
  logic [8:0] cnt_q, cnt_d;
  logic [7:0] nSeq_q, nSeq_d;
  logic       pdReq_q, pdRise, seqRst, calDue, endSeq;

  assign seqRst = rst || !srst_q[SRST_SEQ]; // see R12
  assign pdRise = seqEnterPowerdown && !pdReq_q;

  always_comb begin
    unique case (seqPllCalInterval) // see R21
      CAL_NEVER:   calDue = 1'b0;
      CAL_ALWAYS:  calDue = 1'b1;
      CAL_EVERY16: calDue = (nSeq_q[3:0] & CAL16_MASK) == CAL16_MASK;
      default:     calDue = &nSeq_q;
    endcase
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    nSeq_d = nSeq_q;
    endSeq = 1'b0;
    unique case (st_q)
      SEQ_IDLE: begin
        if (seqEn) st_d = SEQ_DOWN;
      end
      SEQ_DOWN: begin
        if (trig) st_d = SEQ_LOCK;
      end
      SEQ_LOCK: begin
        if (pllLock) begin
          st_d = SEQ_RXW;
          cnt_d = RXW_TBL[seqCfg_q[SEQ_RXW_HI:SEQ_RXW_LO]]; // see R17
        end
      end
      SEQ_RXW: begin
        if (cnt_q == CNT_ZERO) begin
          st_d = SEQ_CSW;
          cnt_d = CSW_TBL[seqCfg_q[SEQ_CSW_HI:SEQ_CSW_LO]]; // see R18
        end else if (adcClkEn) begin
          cnt_d = cnt_q - CNT_ONE; // see R17
        end
      end
      SEQ_CSW: begin
        if (carrierSense) begin
          st_d = SEQ_RXON;
        end else if (cnt_q == CNT_ZERO) begin
          endSeq = 1'b1; // see R23
        end else if (filterClkEn) begin
          cnt_d = cnt_q - CNT_ONE; // see R23
        end
      end
      SEQ_RXON: begin
        if (pdRise) endSeq = 1'b1; // see R20
      end
      SEQ_PLL_CAL_INTERVAL: st_d = SEQ_DOWN;
      default: st_d = SEQ_IDLE;
    endcase
    if (endSeq) begin
      nSeq_d = nSeq_q + 8'h01;
      st_d = calDue ? SEQ_PLL_CAL_INTERVAL : SEQ_DOWN;
    end
    if (pdRise && st_q != SEQ_IDLE && !endSeq) st_d = SEQ_DOWN; // see R20
    if (!seqEn) st_d = SEQ_IDLE; // see R19
  end

  always_ff @(posedge mclk) begin
    if (seqRst) begin
      st_q <= SEQ_IDLE;
      cnt_q <= CNT_ZERO;
      nSeq_q <= READ_ZERO;
      pdReq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      nSeq_q <= nSeq_d;
      pdReq_q <= seqEnterPowerdown;
    end
  end

  // pins, all registered
  logic dio_d, dioOe_d, lock_d, data_clock_pin_d, txAmp_d, rxAmp_d, split;
  logic testOn, tpd_d, rxOn_d, synOn_d, cal_d;
  logic [2:0] tmode_d;

  assign split = ifCfg_q[IF_SPLIT];
  assign testOn = analogTestEnableF || analogTestEnableA;

  always_comb begin
    dio_d = rxData;
    dioOe_d = split || rxTxSelect; // see R2
    lock_d = (split && syncMode) ? rxData : pllLock; // see R2
    data_clock_pin_d = dataClkRaw;
    if (split && !syncMode) begin
      data_clock_pin_d = rxData; // see R2
    end else if (syncMode) begin
      if (ifCfg_q[IF_LOCK_GATE] && powerdownMode == POWERDOWN_MODE_BOTH && !pllLock)
        data_clock_pin_d = 1'b1; // see R4
      if (ifCfg_q[IF_CS_GATE] && !carrierSense)
        data_clock_pin_d = 1'b1; // see R5
    end
    txAmp_d = ifCfg_q[IF_TX_POL]; // see R7
    if (ifCfg_q[IF_TX_CTRL]) txAmp_d = paOn ~^ ifCfg_q[IF_TX_POL]; // see R9
    rxAmp_d = ifCfg_q[IF_RX_POL]; // see R8
    if (ifCfg_q[IF_RX_CTRL]) rxAmp_d = lnaOn ~^ ifCfg_q[IF_RX_POL]; // see R10
    tpd_d = testOn ? ifCfg_q[IF_ANALOG_TEST_POWERDOWN] : 1'b1; // see R11
    tmode_d = testOn ? ifCfg_q[2:0] : TEST_MODE_DFLT; // see R11
    rxOn_d = st_d == SEQ_CSW || st_d == SEQ_RXON || st_d == SEQ_IDLE;
    synOn_d = st_d != SEQ_DOWN;
    cal_d = st_d == SEQ_PLL_CAL_INTERVAL; // see R21
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dataIoPinOut <= 1'b0;
      dataIoPinOe_n <= 1'b1;
      lockPinOut <= 1'b0;
      dataClockPinOut <= 1'b1;
      txAmpEnablePin <= 1'b0;
      rxAmpEnablePin <= 1'b0;
      analogTestPowerdown <= 1'b1;
      testMode <= TEST_MODE_DFLT;
      oscPowerdown <= 1'b0;
      extClockSel <= 1'b0;
      rxChainOn <= 1'b0;
      synthOn <= 1'b0;
      pllCalStart <= 1'b0;
    end else begin
      dataIoPinOut <= dio_d;
      dataIoPinOe_n <= dioOe_d;
      lockPinOut <= lock_d;
      dataClockPinOut <= data_clock_pin_d;
      txAmpEnablePin <= txAmp_d;
      rxAmpEnablePin <= rxAmp_d;
      analogTestPowerdown <= tpd_d;
      testMode <= tmode_d;
      oscPowerdown <= ifCfg_q[IF_BYPASS]; // see R1
      extClockSel <= ifCfg_q[IF_BYPASS]; // see R1
      rxChainOn <= rxOn_d;
      synthOn <= synOn_d;
      pllCalStart <= cal_d;
    end
  end

  assign cfgRdData = rd_q;
  assign unitRst_n = srst_q; // see R12

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_bypass_osc: assert property ( // see R1
    wrIf ##1 !wrIf |=> oscPowerdown == $past(cfgWrData[IF_BYPASS], 2))
    else $error("oscillator bypass not applied");
  a_split_input: assert property (split |=> dataIoPinOe_n) // see R2
    else $error("data pin driven while split");
  a_tx_static: assert property ( // see R7
    !ifCfg_q[IF_TX_CTRL] && $stable(ifCfg_q) |=> txAmpEnablePin == $past(ifCfg_q[IF_TX_POL]))
    else $error("tx amp pin not static");
  a_rx_follow: assert property ( // see R10
    ifCfg_q[IF_RX_CTRL] && ifCfg_q[IF_RX_POL] && lnaOn |=> rxAmpEnablePin)
    else $error("rx amp pin not asserted");
  a_test_default: assert property (!testOn |=> analogTestPowerdown && testMode == TEST_MODE_DFLT) // see R11
    else $error("test defaults wrong");
  a_self_clear: assert property (!wrSrst |=> srst_q == ALL_ONES) // see R13
    else $error("reset bit did not clear");
  a_cs_gate: assert property ( // see R5
    syncMode && !split && ifCfg_q[IF_CS_GATE] && !carrierSense |=> dataClockPinOut)
    else $error("data clock not held high");
  // a power-down request in the same cycle wins over the trigger
  a_trig_start: assert property ( // see R16
    st_q == SEQ_DOWN && trig && seqEn && !pdRise && srst_q[SRST_SEQ] |=> st_q == SEQ_LOCK)
    else $error("trigger lost");
  a_seq_off: assert property (!seqEn |=> st_q == SEQ_IDLE) // see R19
    else $error("sequencer ran outside auto rx");
  a_rxw_none: assert property ( // see R17
    st_q == SEQ_LOCK && pllLock && seqEn && seqCfg_q[SEQ_RXW_HI:SEQ_RXW_LO] == RXW_NONE
    ##1 seqEn [*2]
    |-> ##[1:2] rxChainOn)
    else $error("rx not powered without wait");
  a_pd_return: assert property ($rose(seqEnterPowerdown) && st_q != SEQ_IDLE && seqEn ##1 seqEn // see R20
    |-> st_q == SEQ_DOWN || st_q == SEQ_PLL_CAL_INTERVAL)
    else $error("power-down request ignored");

  c_cs_timeout: cover property (st_q == SEQ_CSW && endSeq);
  c_carrier: cover property (st_q == SEQ_CSW ##1 st_q == SEQ_RXON);
  c_cal: cover property (pllCalStart);
endmodule
`default_nettype wire

// ==== include/rf_seq_pkg.sv ====
// constants, tables and state codes for the pin, reset and sequencing block
// assumes one clock domain; the rate enables come from the clock dividers
package rf_seq_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_IF = 7'h01;
  localparam logic [6:0] ADDR_SRST = 7'h02;
  localparam logic [6:0] ADDR_SEQ = 7'h03;
  localparam logic [6:0] ADDR_SRST_DONE = 7'h41;
  localparam logic [7:0] IF_RESET = 8'h00;
  localparam logic [7:0] SRST_RESET = 8'h00;
  localparam logic [7:0] SEQ_RESET = 8'h8a;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int IF_BYPASS = 7;
  localparam int IF_SPLIT = 6;
  localparam int IF_LOCK_GATE = 5;
  localparam int IF_CS_GATE = 4;
  localparam int IF_TX_CTRL = 3;
  localparam int IF_RX_CTRL = 2;
  localparam int IF_TX_POL = 1;
  localparam int IF_RX_POL = 0;
  localparam int IF_ANALOG_TEST_POWERDOWN = 3;
  localparam int TRIGGER_PIN_SELECT = 7;
  localparam int SEQ_RXW_HI = 6;
  localparam int SEQ_RXW_LO = 4;
  localparam int SEQ_CSW_HI = 3;
  localparam int SEQ_CSW_LO = 0;
  localparam int SRST_SEQ = 1;
  localparam logic [1:0] POWERDOWN_MODE_BOTH = 2'h1;
  localparam logic [1:0] POWERDOWN_MODE_AUTO = 2'h3;
  localparam logic [1:0] CAL_NEVER = 2'h0;
  localparam logic [1:0] CAL_ALWAYS = 2'h1;
  localparam logic [1:0] CAL_EVERY16 = 2'h2;
  localparam logic [3:0] CAL16_MASK = 4'hf;
  localparam logic [2:0] TEST_MODE_DFLT = 3'h1;
  localparam logic [2:0] RXW_NONE = 3'h7;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_ONE = 9'h001;
  // adc clock periods per code; last code adds no wait
  localparam logic [8:0] RXW_TBL [8] = '{9'h020, 9'h02c, 9'h040, 9'h058,
                                         9'h080, 9'h0b0, 9'h100, 9'h000};
  // filter clock periods per code
  localparam logic [8:0] CSW_TBL [16] = '{9'h014, 9'h016, 9'h018, 9'h01a,
                                          9'h01c, 9'h01e, 9'h020, 9'h024,
                                          9'h028, 9'h02c, 9'h030, 9'h034,
                                          9'h038, 9'h03c, 9'h040, 9'h048};
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_DOWN = 3'h1,
    SEQ_LOCK = 3'h2,
    SEQ_RXW  = 3'h3,
    SEQ_CSW  = 3'h4,
    SEQ_RXON = 3'h5,
    SEQ_PLL_CAL_INTERVAL  = 3'h6
  } seq_state_e;
endpackage

// ==== sim/host_mcu_model.sv ====
// host microcontroller model: config port strobes, trigger pins, done poll
// assumes the bench calls its tasks; everything changes on falling edges
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model
  import rf_seq_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic [7:0]                    cfgRdData,
  output logic      [rf_seq_pkg::ADDR_W-1:0] cfgAddr,
  output logic                               cfgWrEn,
  output logic      [7:0]                    cfgWrData,
  output logic                               cfgRdEn,
  output logic                               dataIoPinIn,
  output logic                               powerSelPin
);
  // pins idle high; whole-chip reset is the normal path
  initial begin
    cfgAddr = '0;
    cfgWrEn = 1'b0;
    cfgWrData = 8'h00;
    cfgRdEn = 1'b0;
    dataIoPinIn = 1'b1;
    powerSelPin = 1'b1;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    cfgAddr = a;
    cfgWrData = d;
    cfgWrEn = 1'b1;
    @(negedge mclk);
    cfgWrEn = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge mclk);
    cfgAddr = a;
    cfgRdEn = 1'b1;
    @(negedge mclk);
    cfgRdEn = 1'b0;
    d = cfgRdData;
  endtask
  // low long enough for the two-stage synchroniser to see it
  task automatic fall(input logic onData);
    @(negedge mclk);
    if (onData) dataIoPinIn = 1'b0;
    else powerSelPin = 1'b0;
    repeat (4) @(negedge mclk);
    dataIoPinIn = 1'b1;
    powerSelPin = 1'b1;
  endtask
  task automatic waitDone(output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(ADDR_SRST_DONE, v);
      ok = (v === ALL_ONES);
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the pin, soft reset and sequencing block
// assumes the host model drives the config port and trigger pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rf_seq_pkg::*;
  logic mclk, rst, rxTxSelect, seqEnterPowerdown, analogTestEnableF, analogTestEnableA;
  logic syncMode, pllLock, carrierSense, paOn, lnaOn, rxData, dataClkRaw;
  logic adcClkEn, filterClkEn, oscPowerdown, extClockSel, dataIoPinOut, dataIoPinOe_n;
  logic lockPinOut, dataClockPinOut, txAmpEnablePin, rxAmpEnablePin, analogTestPowerdown;
  logic rxChainOn, synthOn, pllCalStart, cfgWrEn, cfgRdEn, dataIoPinIn, powerSelPin, ok;
  logic [1:0] powerdownMode, seqPllCalInterval;
  logic [2:0] testMode;
  logic [6:0] cfgAddr;
  logic [7:0] unitClkRunning, cfgRdData, cfgWrData, unitRst_n, v;
  int errors, numChecks, n, m, cal;
  rf_pin_reset_sequencing_ctrl rf_pin_reset_sequencing_ctrl_inst (.mclk, .rst, .cfgAddr,
    .cfgWrEn, .cfgWrData, .cfgRdEn, .rxTxSelect, .powerdownMode, .seqPllCalInterval,
    .seqEnterPowerdown, .analogTestEnableF, .analogTestEnableA, .dataIoPinIn, .powerSelPin,
    .syncMode, .pllLock, .carrierSense, .paOn, .lnaOn, .rxData, .dataClkRaw, .adcClkEn,
    .filterClkEn, .unitClkRunning, .cfgRdData, .oscPowerdown, .extClockSel, .dataIoPinOut,
    .dataIoPinOe_n, .lockPinOut, .dataClockPinOut, .txAmpEnablePin, .rxAmpEnablePin,
    .analogTestPowerdown, .testMode, .unitRst_n, .rxChainOn, .synthOn, .pllCalStart);
  host_mcu_model host_mcu_model_inst (.mclk, .cfgRdData, .cfgAddr, .cfgWrEn, .cfgWrData,
    .cfgRdEn, .dataIoPinIn, .powerSelPin);
  always #20 mclk = ~mclk;
  // filter rate at half the clock, so the carrier wait counts enables, not clocks
  always @(negedge mclk) filterClkEn = rst || !filterClkEn;
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wrIf(input logic [7:0] d);
    host_mcu_model_inst.wr(ADDR_IF, d);
    tick(2);
  endtask
  task automatic testResetState();
    chk("testPd", 8'h01, 8'(analogTestPowerdown));
    chk("testMode", 8'h01, 8'(testMode));
    host_mcu_model_inst.rd(ADDR_IF, v);
    chk("ifReset", IF_RESET, v);
    host_mcu_model_inst.rd(ADDR_SEQ, v);
    chk("seqReset", SEQ_RESET, v);
    host_mcu_model_inst.rd(7'h10, v);
    chk("unmapped", READ_ZERO, v);
  endtask
  task automatic testPins();
    wrIf(8'h83);
    chk("oscPd", 8'h01, 8'(oscPowerdown));
    chk("extClk", 8'h01, 8'(extClockSel));
    chk("txPinStatic", 8'h01, 8'(txAmpEnablePin));
    chk("rxPinStatic", 8'h01, 8'(rxAmpEnablePin));
    paOn = 1'b1;
    wrIf(8'h0c);
    chk("txPinActLow", 8'h00, 8'(txAmpEnablePin));
    chk("rxPinIdle", 8'h01, 8'(rxAmpEnablePin));
    lnaOn = 1'b1;
    wrIf(8'h05);
    chk("rxPinActHi", 8'h01, 8'(rxAmpEnablePin));
    analogTestEnableA = 1'b1;
    tick(2);
    chk("testPdSel", 8'h00, 8'(analogTestPowerdown));
    chk("testModeSel", 8'h05, 8'(testMode));
    analogTestEnableA = 1'b0;
    rxData = 1'b1;
    wrIf(8'h00);
    chk("dataOe", 8'h00, 8'(dataIoPinOe_n));
    chk("dataOut", 8'h01, 8'(dataIoPinOut));
    syncMode = 1'b1;
    wrIf(8'h40);
    chk("dataOeSplit", 8'h01, 8'(dataIoPinOe_n));
    chk("lockRx", 8'h01, 8'(lockPinOut));
    wrIf(8'h10);
    chk("dclkNoCs", 8'h01, 8'(dataClockPinOut));
    carrierSense = 1'b1;
    tick(2);
    chk("dclkCs", 8'h00, 8'(dataClockPinOut));
    carrierSense = 1'b0;
    powerdownMode = POWERDOWN_MODE_BOTH;
    wrIf(8'h20);
    chk("dclkUnlocked", 8'h01, 8'(dataClockPinOut));
    pllLock = 1'b1;
    tick(2);
    chk("dclkLocked", 8'h00, 8'(dataClockPinOut));
    pllLock = 1'b0;
    powerdownMode = 2'h0;
  endtask
  task automatic testSoftReset();
    // unit 0 clock stopped, so only its done bit stalls
    unitClkRunning = 8'hfe;
    host_mcu_model_inst.wr(ADDR_SRST, 8'hfe);
    chk("unitRst", 8'hfe, unitRst_n);
    tick(1);
    chk("unitRstClr", ALL_ONES, unitRst_n);
    host_mcu_model_inst.rd(ADDR_SRST_DONE, v);
    chk("doneStalled", 8'hfe, v);
    unitClkRunning = ALL_ONES;
    host_mcu_model_inst.waitDone(ok);
    chk("doneAll", 8'h01, 8'(ok));
  endtask
  // synthOn must rise within 10 cycles of a trigger
  task automatic waitSynth(input string nm);
    for (n = 0; n < 10 && synthOn !== 1'b1; n++) tick(1);
    chk(nm, 8'h01, 8'(synthOn));
  endtask
  task automatic testSequencer();
    host_mcu_model_inst.wr(ADDR_SEQ, 8'hf0);
    seqPllCalInterval = CAL_ALWAYS;
    powerdownMode = POWERDOWN_MODE_AUTO;
    tick(3);
    chk("downRx", 8'h00, 8'(rxChainOn));
    host_mcu_model_inst.fall(1'b0);
    waitSynth("pselStart");
    pllLock = 1'b1;
    for (n = 0; n < 10 && rxChainOn !== 1'b1; n++) tick(1);
    chk("rxOnNoWait", 8'h01, 8'(rxChainOn));
    m = 0;
    cal = 0;
    // fixed window: count rx-on cycles and calibration pulses;
    // 20 filter periods at half rate is about 40 clocks
    for (n = 0; n < 60; n++) begin
      m += int'(rxChainOn === 1'b1);
      cal += int'(pllCalStart === 1'b1);
      tick(1);
    end
    chk("csWindow", 8'h01, 8'(m >= 39 && m <= 43));
    chk("calPulse", 8'h01, 8'(cal));
    pllLock = 1'b0;
    // second sequence is not a 16th one, so no calibration
    seqPllCalInterval = CAL_EVERY16;
    host_mcu_model_inst.wr(ADDR_SEQ, 8'h70);
    wrIf(8'h40);
    host_mcu_model_inst.fall(1'b0);
    tick(8);
    chk("pselIgnored", 8'h00, 8'(synthOn));
    host_mcu_model_inst.fall(1'b1);
    waitSynth("dataStart");
    carrierSense = 1'b1;
    pllLock = 1'b1;
    tick(60);
    chk("rxHeld", 8'h01, 8'(rxChainOn));
    cal = 0;
    seqEnterPowerdown = 1'b1;
    for (n = 0; n < 6; n++) begin
      tick(1);
      cal += int'(pllCalStart === 1'b1);
    end
    chk("forcedDown", 8'h00, 8'(rxChainOn));
    chk("calSkipped", 8'h00, 8'(cal));
  endtask
  initial begin
    {mclk, rxTxSelect, seqEnterPowerdown, analogTestEnableF, analogTestEnableA} = '0;
    {syncMode, pllLock, carrierSense, paOn, lnaOn, rxData, dataClkRaw} = '0;
    {powerdownMode, seqPllCalInterval, unitClkRunning} = '0;
    {adcClkEn, rst} = 2'h3;
    {errors, numChecks} = '0;
    tick(10);
    rst = 1'b0;
    tick(2);
    testResetState();
    testPins();
    testSoftReset();
    testSequencer();
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end
endmodule
`default_nettype wire
